// File: bec_pkg.sv
// ****************************************************************
// shared constants and types of the init control block
// ****************************************************************
package bec_pkg;

	// register placement and reset image
	localparam logic [7:0]  CTRL_OFFSET   = 8'h6C;
	localparam logic [31:0] CTRL_RESET    = 32'h0000767E;

	// field positions inside the control register
	localparam int CMD_DMA_RD_LSB = 0;
	localparam int CMD_DMA_WR_LSB = 4;
	localparam int CMD_DM_RD_LSB  = 8;
	localparam int CMD_DM_WR_LSB  = 12;
	localparam int CMD_W          = 4;
	localparam int GPO_BIT        = 16;
	localparam int GPI_BIT        = 17;
	localparam int EE_CLK_BIT     = 24;
	localparam int EE_CS_BIT      = 25;
	localparam int EE_DI_BIT      = 26;
	localparam int EE_DO_BIT      = 27;
	localparam int EE_PRESENT_BIT = 28;
	localparam int RELOAD_BIT     = 29;
	localparam int SOFT_RST_BIT   = 30;
	localparam int INIT_DONE_BIT  = 31;

	// byte lanes of the register
	localparam int LANE_CMD_LO = 0;
	localparam int LANE_CMD_HI = 1;
	localparam int LANE_GPIO   = 2;
	localparam int LANE_EE     = 3;

	// default image, word index is the byte offset divided by two
	localparam logic [7:0]  IMG_SP0_RANGE_HI = 8'h0A;
	localparam logic [7:0]  IMG_SP0_RANGE_LO = 8'h0B;
	localparam logic [7:0]  IMG_SP0_DESC_HI  = 8'h16;
	localparam logic [7:0]  IMG_SP0_DESC_LO  = 8'h17;
	localparam logic [7:0]  IMG_SP1_RANGE_HI = 8'h24;
	localparam logic [7:0]  IMG_SP1_RANGE_LO = 8'h25;
	localparam logic [7:0]  IMG_SP1_DESC_HI  = 8'h28;
	localparam logic [7:0]  IMG_SP1_DESC_LO  = 8'h29;
	localparam logic [7:0]  IMG_WORDS        = 8'h2C;
	localparam logic [31:0] DEF_SP0_RANGE    = {16'hFFFF, 16'hFE00};
	localparam logic [31:0] DEF_SP0_DESC     = {16'h4200, 16'h0143};
	localparam logic [31:0] DEF_SP1_RANGE    = {16'hFFFF, 16'hFFF0};
	localparam logic [31:0] DEF_SP1_DESC     = {16'h0000, 16'h01C1};
	localparam logic [15:0] BLANK_WORD       = 16'hFFFF;

	// serial memory read command: start bit then opcode
	localparam logic [2:0]  EE_READ_CMD  = 3'h6;
	localparam int          EE_ADDR_BITS = 6;
	localparam int          EE_WORD_W    = 16;

	// serial clock timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int EE_HALF_NS    = 1000;
	localparam int EE_HALF_CYC   = (EE_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef struct packed {
		logic [3:0] dm_wr;
		logic [3:0] dm_rd;
		logic [3:0] dma_wr;
		logic [3:0] dma_rd;
	} bec_cmd_codes_t;

	typedef struct packed {
		logic [31:0] sp0_range;
		logic [31:0] sp0_desc;
		logic [31:0] sp1_range;
		logic [31:0] sp1_desc;
	} bec_local_cfg_t;

	typedef struct packed {
		logic sk;
		logic cs;
		logic di;
	} bec_ee_pins_t;

	typedef enum {BEC_IDLE, BEC_CMD, BEC_DATA} bec_rd_state_t;

endpackage

// File: bec_serial_reader.sv
`timescale 1ns/1ns
// ****************************************************************
// sequential reader of the serial configuration memory
// ****************************************************************
module bec_serial_reader #(
	parameter int WORDS     = 44,
	parameter int ADDR_BITS = bec_pkg::EE_ADDR_BITS,
	parameter int HALF_CYC  = bec_pkg::EE_HALF_CYC
) (
	input  wire logic                      mclk,
	input  wire logic                      rstn,
	input  wire logic                      start,
	input  wire logic                      ee_do,
	output bec_pkg::bec_ee_pins_t          pins,
	output logic                           busy,
	output logic                           done,
	output logic                           word_valid,
	output logic [7:0]                     word_idx,
	output logic [bec_pkg::EE_WORD_W-1:0]  word_data
);
	localparam int CMD_BITS = 3 + ADDR_BITS;
	localparam int DIV_W    = $clog2(HALF_CYC + 1);
	localparam int CNT_W    = $clog2(CMD_BITS + bec_pkg::EE_WORD_W + 1);

	bec_pkg::bec_rd_state_t   state;
	logic [DIV_W-1:0]         div;
	logic                     tick;
	logic                     phase;
	logic [CNT_W-1:0]         bitcnt;
	logic [CMD_BITS-1:0]      cmd_sh;
	logic [bec_pkg::EE_WORD_W-1:0] data_sh;

	// half period enable of the serial clock
	assign tick = (div == DIV_W'(HALF_CYC - 1));

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			div <= '0;
		end else if (state == bec_pkg::BEC_IDLE || tick) begin
			div <= '0;
		end else begin
			div <= div + 1'b1;
		end
	end

	// command shift, data capture and word counting
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state      <= bec_pkg::BEC_IDLE;
			phase      <= 1'b0;
			bitcnt     <= '0;
			cmd_sh     <= '0;
			data_sh    <= '0;
			pins       <= '0;
			done       <= 1'b0;
			word_valid <= 1'b0;
			word_idx   <= '0;
			word_data  <= '0;
		end else begin
			done       <= 1'b0;
			word_valid <= 1'b0;
			case (state)
				bec_pkg::BEC_IDLE: begin
					if (start) begin
						state    <= bec_pkg::BEC_CMD;
						cmd_sh   <= {bec_pkg::EE_READ_CMD, {ADDR_BITS{1'b0}}};
						pins.cs  <= 1'b1;
						pins.sk  <= 1'b0;
						pins.di  <= bec_pkg::EE_READ_CMD[2];
						phase    <= 1'b0;
						bitcnt   <= '0;
						word_idx <= '0;
					end
				end
				bec_pkg::BEC_CMD: begin
					if (tick) begin
						phase   <= ~phase;
						pins.sk <= ~phase; // memory takes di on the rising edge
						if (phase) begin
							cmd_sh  <= {cmd_sh[CMD_BITS-2:0], 1'b0};
							pins.di <= cmd_sh[CMD_BITS-2];
							if (bitcnt == CNT_W'(CMD_BITS - 1)) begin
								state  <= bec_pkg::BEC_DATA;
								bitcnt <= '0;
							end else begin
								bitcnt <= bitcnt + 1'b1;
							end
						end
					end
				end
				bec_pkg::BEC_DATA: begin
					if (tick) begin
						phase   <= ~phase;
						pins.sk <= ~phase;
						pins.di <= 1'b0;
						if (phase) begin
							data_sh <= {data_sh[bec_pkg::EE_WORD_W-2:0], ee_do}; // sample before falling edge
							if (bitcnt == CNT_W'(bec_pkg::EE_WORD_W - 1)) begin
								bitcnt     <= '0;
								word_valid <= 1'b1;
								word_data  <= {data_sh[bec_pkg::EE_WORD_W-2:0], ee_do};
								if (word_idx == 8'(WORDS - 1)) begin
									state   <= bec_pkg::BEC_IDLE;
									pins.cs <= 1'b0;
									done    <= 1'b1;
								end
							end else begin
								bitcnt <= bitcnt + 1'b1;
							end
						end
					end
					// index advances one cycle after the word is shown
					if (word_valid) begin
						word_idx <= word_idx + 1'b1;
					end
				end
				default: begin
					state <= bec_pkg::BEC_IDLE;
				end
			endcase
		end
	end

	assign busy = (state != bec_pkg::BEC_IDLE);

endmodule // bec_serial_reader

// File: bec_init_control.sv
`timescale 1ns/1ns
// Summary of operation
// (R01) dma read cycles drive bits 3:0 code
// (R02) dma write cycles drive bits 7:4 code
// (R03) direct master reads drive bits 11:8 code
// (R04) direct master writes drive bits 15:12 code
// (R05) bit 16 drives the general output pin
// (R06) bit 17 reads the general input pin
// (R07) bit 24 drives the serial memory clock
// (R08) bit 25 drives the serial chip select
// (R09) bit 26 drives serial memory data input
// (R10) bit 27 reads serial memory data output
// (R11) bit 28 reports serial memory present
// (R12) writing 1 to clear bit 29 reloads
// (R13) bit 30 holds local side in reset
// (R14) only host access clears software reset
// (R15) bit 31 init done, else retry
// (R16) bypass pin low forces init done
// (R17) memory programmable by software bit banging
// (R18) default space 0 range ffff fe00
// (R19) default space 1 range and descriptor
// (R20) default space 0 descriptor 4200 0143
// (R21) register at 6Ch, never loaded
// (R22) software keeps select high, data before clock

// ****************************************************************
// control register, command codes and configuration loading
// ****************************************************************
module bec_init_control #(
	parameter int LOAD_WORDS = 44,
	parameter int HALF_CYC   = bec_pkg::EE_HALF_CYC
) (
	input  wire logic                   mclk,
	input  wire logic                   rstn,
	input  wire logic                   host_req,
	input  wire logic                   host_we,
	input  wire logic [7:0]             host_addr,
	input  wire logic [3:0]             host_be,
	input  wire logic [31:0]            host_wdata,
	output logic                        host_ack,
	output logic                        host_retry,
	output logic [31:0]                 host_rdata,
	input  wire logic                   cyc_dma_rd,
	input  wire logic                   cyc_dma_wr,
	input  wire logic                   cyc_dm_rd,
	input  wire logic                   cyc_dm_wr,
	output logic [3:0]                  pci_cmd,
	output logic                        general_purpose_output_pin,
	input  wire logic                   general_purpose_input_pin,
	output logic                        ee_sk,
	output logic                        ee_cs,
	output logic                        ee_di,
	input  wire logic                   ee_do,
	output logic                        local_reset_output_n,
	input  wire logic                   init_bypass_input_n,
	output bec_pkg::bec_local_cfg_t     local_cfg
);
	bec_pkg::bec_cmd_codes_t  codes;
	bec_pkg::bec_ee_pins_t    sw_pins;
	bec_pkg::bec_ee_pins_t    eng_pins;
	logic                     gpo;
	logic                     soft_reset;
	logic                     reload_busy;
	logic                     ee_present;
	logic                     init_done;
	logic                     init_done_eff;
	logic                     boot_pending;
	logic                     img_valid;
	logic                     start;
	logic                     eng_busy;
	logic                     eng_done;
	logic                     word_valid;
	logic [7:0]               word_idx;
	logic [15:0]              word_data;
	logic                     hit;
	logic                     wr;
	logic [31:0]              ctrl_view;

	// ****************************************************************
	// host access decode
	// ****************************************************************

	// bypass pin overrides the done flag
	assign init_done_eff = init_done | ~init_bypass_input_n; // see (R16)

	// register sits at one runtime offset, nothing else maps here
	assign hit = (host_addr == bec_pkg::CTRL_OFFSET); // see (R21)
	assign wr  = host_req & host_we & hit & init_done_eff;

	// byte lane test for write strobes
	function automatic logic lane(input logic [3:0] be, input int idx);
		lane = be[idx];
	endfunction

	// assembled read view of the control register
	always_comb begin
		ctrl_view = '0;
		ctrl_view[bec_pkg::CMD_DMA_RD_LSB +: bec_pkg::CMD_W] = codes.dma_rd;
		ctrl_view[bec_pkg::CMD_DMA_WR_LSB +: bec_pkg::CMD_W] = codes.dma_wr;
		ctrl_view[bec_pkg::CMD_DM_RD_LSB  +: bec_pkg::CMD_W] = codes.dm_rd;
		ctrl_view[bec_pkg::CMD_DM_WR_LSB  +: bec_pkg::CMD_W] = codes.dm_wr;
		ctrl_view[bec_pkg::GPO_BIT]        = gpo;
		ctrl_view[bec_pkg::GPI_BIT]        = general_purpose_input_pin; // see (R06)
		ctrl_view[bec_pkg::EE_CLK_BIT]     = sw_pins.sk;
		ctrl_view[bec_pkg::EE_CS_BIT]      = sw_pins.cs;
		ctrl_view[bec_pkg::EE_DI_BIT]      = sw_pins.di;
		ctrl_view[bec_pkg::EE_DO_BIT]      = ee_do; // see (R10)
		ctrl_view[bec_pkg::EE_PRESENT_BIT] = ee_present; // see (R11)
		ctrl_view[bec_pkg::RELOAD_BIT]     = reload_busy;
		ctrl_view[bec_pkg::SOFT_RST_BIT]   = soft_reset;
		ctrl_view[bec_pkg::INIT_DONE_BIT]  = init_done_eff; // see (R15)
	end

	// answer one cycle after the request, retry until init is done
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			host_ack   <= 1'b0;
			host_retry <= 1'b0;
			host_rdata <= '0;
		end else begin
			host_ack   <= host_req & init_done_eff;
			host_retry <= host_req & ~init_done_eff; // see (R15)
			if (host_req && !host_we && init_done_eff) begin
				host_rdata <= hit ? ctrl_view : '0;
			end
		end
	end

	// ****************************************************************
	// writable fields
	// ****************************************************************

	// command codes, reset value taken from the register image
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			codes <= bec_pkg::CTRL_RESET[15:0];
		end else if (wr) begin
			if (lane(host_be, bec_pkg::LANE_CMD_LO)) begin
				codes.dma_rd <= host_wdata[bec_pkg::CMD_DMA_RD_LSB +: bec_pkg::CMD_W];
				codes.dma_wr <= host_wdata[bec_pkg::CMD_DMA_WR_LSB +: bec_pkg::CMD_W];
			end
			if (lane(host_be, bec_pkg::LANE_CMD_HI)) begin
				codes.dm_rd <= host_wdata[bec_pkg::CMD_DM_RD_LSB +: bec_pkg::CMD_W];
				codes.dm_wr <= host_wdata[bec_pkg::CMD_DM_WR_LSB +: bec_pkg::CMD_W];
			end
		end
	end

	// general purpose output bit
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			gpo <= bec_pkg::CTRL_RESET[bec_pkg::GPO_BIT];
		end else if (wr && lane(host_be, bec_pkg::LANE_GPIO)) begin
			gpo <= host_wdata[bec_pkg::GPO_BIT];
		end
	end

	// bit banged serial memory pins, the way software programs it
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sw_pins <= '0;
		end else if (wr && lane(host_be, bec_pkg::LANE_EE)) begin
			sw_pins.sk <= host_wdata[bec_pkg::EE_CLK_BIT]; // see (R07)
			sw_pins.cs <= host_wdata[bec_pkg::EE_CS_BIT]; // see (R08)
			sw_pins.di <= host_wdata[bec_pkg::EE_DI_BIT]; // see (R09) (R17)
		end
	end

	// software reset, only this host port can set or clear it
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			soft_reset <= bec_pkg::CTRL_RESET[bec_pkg::SOFT_RST_BIT];
		end else if (wr && lane(host_be, bec_pkg::LANE_EE)) begin
			soft_reset <= host_wdata[bec_pkg::SOFT_RST_BIT]; // see (R14)
		end
	end

	// ****************************************************************
	// configuration loading
	// ****************************************************************

	// first load after reset, then on request while no reload runs
	assign start = ~eng_busy & (boot_pending | (wr & lane(host_be, bec_pkg::LANE_EE)
		& host_wdata[bec_pkg::RELOAD_BIT] & ~reload_busy)); // see (R12)

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			boot_pending <= 1'b1;
		end else if (start) begin
			boot_pending <= 1'b0;
		end
	end

	// reload flag reads 1 until the load completes
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			reload_busy <= bec_pkg::CTRL_RESET[bec_pkg::RELOAD_BIT];
		end else if (start && !boot_pending) begin
			reload_busy <= 1'b1; // see (R12)
		end else if (eng_done) begin
			reload_busy <= 1'b0;
		end
	end

	// local init completes when the first load ends
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			init_done <= bec_pkg::CTRL_RESET[bec_pkg::INIT_DONE_BIT];
		end else if (eng_done) begin
			init_done <= 1'b1; // see (R15)
		end
	end

	// a blank first word means no memory is fitted
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ee_present <= bec_pkg::CTRL_RESET[bec_pkg::EE_PRESENT_BIT];
			img_valid  <= 1'b0;
		end else if (word_valid && word_idx == 8'h00) begin
			ee_present <= (word_data != bec_pkg::BLANK_WORD); // see (R11)
			img_valid  <= (word_data != bec_pkg::BLANK_WORD);
		end
	end

	// local configuration, the control register itself is never loaded
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			local_cfg.sp0_range <= bec_pkg::DEF_SP0_RANGE; // see (R18)
			local_cfg.sp0_desc  <= bec_pkg::DEF_SP0_DESC; // see (R20)
			local_cfg.sp1_range <= bec_pkg::DEF_SP1_RANGE; // see (R19)
			local_cfg.sp1_desc  <= bec_pkg::DEF_SP1_DESC; // see (R19)
		end else if (word_valid && img_valid) begin
			// upper word arrives first in each pair
			if (word_idx == bec_pkg::IMG_SP0_RANGE_HI) begin
				local_cfg.sp0_range[31:16] <= word_data; // see (R18)
			end else if (word_idx == bec_pkg::IMG_SP0_RANGE_LO) begin
				local_cfg.sp0_range[15:0] <= word_data;
			end else if (word_idx == bec_pkg::IMG_SP0_DESC_HI) begin
				local_cfg.sp0_desc[31:16] <= word_data; // see (R20)
			end else if (word_idx == bec_pkg::IMG_SP0_DESC_LO) begin
				local_cfg.sp0_desc[15:0] <= word_data;
			end else if (word_idx == bec_pkg::IMG_SP1_RANGE_HI) begin
				local_cfg.sp1_range[31:16] <= word_data; // see (R19)
			end else if (word_idx == bec_pkg::IMG_SP1_RANGE_LO) begin
				local_cfg.sp1_range[15:0] <= word_data;
			end else if (word_idx == bec_pkg::IMG_SP1_DESC_HI) begin
				local_cfg.sp1_desc[31:16] <= word_data;
			end else if (word_idx == bec_pkg::IMG_SP1_DESC_LO) begin
				local_cfg.sp1_desc[15:0] <= word_data;
			end
		end
	end

	bec_serial_reader #(
		.WORDS      (LOAD_WORDS),
		.ADDR_BITS  (bec_pkg::EE_ADDR_BITS),
		.HALF_CYC   (HALF_CYC)
	) u_reader (
		.mclk       (mclk),
		.rstn       (rstn),
		.start      (start),
		.ee_do      (ee_do),
		.pins       (eng_pins),
		.busy       (eng_busy),
		.done       (eng_done),
		.word_valid (word_valid),
		.word_idx   (word_idx),
		.word_data  (word_data)
	);

	// ****************************************************************
	// pins toward the board
	// ****************************************************************

	// loader owns the memory pins while busy, software otherwise
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ee_sk <= 1'b0;
			ee_cs <= 1'b0;
			ee_di <= 1'b0;
		end else begin
			ee_sk <= eng_busy ? eng_pins.sk : sw_pins.sk; // see (R07)
			ee_cs <= eng_busy ? eng_pins.cs : sw_pins.cs; // see (R08)
			ee_di <= eng_busy ? eng_pins.di : sw_pins.di; // see (R09)
		end
	end

	// general output and local reset
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			general_purpose_output_pin <= 1'b0;
			local_reset_output_n       <= 1'b0;
		end else begin
			general_purpose_output_pin <= gpo; // see (R05)
			local_reset_output_n       <= ~soft_reset; // see (R13)
		end
	end

	// bus command for the current master cycle
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pci_cmd <= '0;
		end else if (cyc_dma_rd) begin
			pci_cmd <= codes.dma_rd; // see (R01)
		end else if (cyc_dma_wr) begin
			pci_cmd <= codes.dma_wr; // see (R02)
		end else if (cyc_dm_rd) begin
			pci_cmd <= codes.dm_rd; // see (R03)
		end else if (cyc_dm_wr) begin
			pci_cmd <= codes.dm_wr; // see (R04)
		end
	end

endmodule // bec_init_control

// File: bec_init_control_chk.sv
`timescale 1ns/1ns
// ****************************************************************
// port level checks of the init control block
// ****************************************************************
module bec_init_control_chk (
	input logic				mclk,
	input logic				rstn,
	input logic				host_req,
	input logic				host_we,
	input logic [7:0]			host_addr,
	input logic [3:0]			host_be,
	input logic [31:0]			host_wdata,
	input logic				host_ack,
	input logic				host_retry,
	input logic [31:0]			host_rdata,
	input logic				cyc_dma_rd,
	input logic				cyc_dma_wr,
	input logic				cyc_dm_rd,
	input logic				cyc_dm_wr,
	input logic [3:0]			pci_cmd,
	input logic				general_purpose_output_pin,
	input logic				general_purpose_input_pin,
	input logic				ee_sk,
	input logic				ee_cs,
	input logic				ee_di,
	input logic				ee_do,
	input logic				local_reset_output_n,
	input logic				init_bypass_input_n,
	input bec_pkg::bec_local_cfg_t	local_cfg
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);

	// host accesses aimed at the control register
	sequence s_read;
		host_req && !host_we && host_addr == 8'h6C;
	endsequence
	sequence s_write(int lane);
		host_req && host_we && host_addr == 8'h6C && host_be[lane];
	endsequence

	// answer timing and read data holding
	a_one_answer: assert property (host_req |=> host_ack ^ host_retry)
		else $error("request not answered once");
	a_no_spurious: assert property (!host_req |=> !host_ack && !host_retry)
		else $error("answer without request");
	a_retry_rdata: assert property (host_retry |-> $stable(host_rdata))
		else $error("refused access changed read data");
	a_rdata_hold: assert property (!(host_req && !host_we) |=> $stable(host_rdata))
		else $error("read data moved without a read");
	a_bypass_done: assert property ((s_read and !init_bypass_input_n) |=> host_ack && host_rdata[31])
		else $error("bypass did not force init done");
	a_gpi_live: assert property (s_read ##1 host_ack |-> host_rdata[17] == $past(general_purpose_input_pin))
		else $error("input pin not seen in read data");
	a_unmap_zero: assert property (host_req && !host_we && host_addr != 8'h6C ##1 host_ack |-> host_rdata == 32'h0)
		else $error("unmapped read returned data");

	// outputs following register writes and master cycles
	a_gpo_write: assert property (s_write(2) ##1 host_ack |=> general_purpose_output_pin == $past(host_wdata[16], 2))
		else $error("output pin not following bit 16");
	a_srst_pin: assert property (s_write(3) ##1 host_ack |=> local_reset_output_n == !$past(host_wdata[30], 2))
		else $error("local reset not following bit 30");
	a_cmd_dmard: assert property (s_read ##1 host_ack && cyc_dma_rd |=> pci_cmd == $past(host_rdata[3:0]))
		else $error("dma read code wrong");
	a_cmd_dmwr: assert property (s_read ##1 host_ack && cyc_dm_wr && !cyc_dma_rd && !cyc_dma_wr && !cyc_dm_rd
		|=> pci_cmd == $past(host_rdata[15:12]))
		else $error("direct master write code wrong");
endmodule // bec_init_control_chk

bind bec_init_control bec_init_control_chk i_chk (.*);

// File: bec_ee_model.sv
`timescale 1ns/1ns
// ****************************************************************
// behavioural serial configuration memory, sequential read only
// ****************************************************************
module bec_ee_model (
	input logic	ee_sk,
	input logic	ee_cs,
	input logic	ee_di,
	input logic	ee_blank,
	output logic	ee_do
);
	logic [15:0]	cnt = 16'h0;
	logic [8:0]	hdr = 9'h0;
	logic [15:0]	wd;
	logic		do_q = 1'b0;

	// header shifts in on each clock rise, then words shift out msb first
	always @(posedge ee_sk or negedge ee_cs) begin
		if (!ee_cs) begin
			cnt <= 16'h0;
		end else begin
			cnt <= cnt + 16'h1;
			wd = ee_blank ? 16'hFFFF : 16'hA500 + 16'(hdr[5:0]) + ((cnt - 16'h9) >> 4);
			if (cnt < 16'h9)
				hdr <= {hdr[7:0], ee_di};
			else if (hdr[8:6] == 3'b110)
				do_q <= wd[4'(4'h8 - cnt[3:0])];
		end
	end

	// a deselected part drives the inverse of its last bit, so never show the old bit
	assign ee_do = ee_cs ? do_q : ~do_q;
endmodule // bec_ee_model

// File: tb_top.sv
`timescale 1ns/1ns
// ****************************************************************
// testbench of the init control block
// ****************************************************************
module tb_top;
	localparam logic [127:0] DEF_CFG = {32'hFFFFFE00, 32'h42000143, 32'hFFFFFFF0, 32'h000001C1};
	localparam logic [127:0] LOADED = {64'hA50AA50BA516A517, 64'hA524A525A528A529};
	localparam logic [31:0] MASK27 = 32'hF7FFFFFF;
	localparam logic [8:0] HDR = 9'b110000001;
	logic				mclk = 1'b0, rstn = 1'b0, host_req = 1'b0, host_we = 1'b0;
	logic [7:0]			host_addr = 8'h00;
	logic [3:0]			host_be = 4'h0, pci_cmd;
	logic [31:0]			host_wdata = 32'h0, host_rdata, rd = 32'h0;
	logic				host_ack, host_retry, acked, retried;
	logic				cyc_dma_rd = 1'b0, cyc_dma_wr = 1'b0, cyc_dm_rd = 1'b0, cyc_dm_wr = 1'b0;
	logic				general_purpose_output_pin, general_purpose_input_pin = 1'b1;
	logic				ee_sk, ee_cs, ee_di, ee_do, ee_blank = 1'b0;
	logic				local_reset_output_n, init_bypass_input_n = 1'b1;
	bec_pkg::bec_local_cfg_t	local_cfg;
	logic [15:0]			w;
	int				err_total = 0, n_checks = 0, cyc = 0;

	bec_init_control #(.LOAD_WORDS(42), .HALF_CYC(2)) i_dut (.*);
	bec_ee_model i_ee (.*);

	// clock and run length guard
	always #5 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			$display("[ERR] %0t run too long", $time);
			results();
		end
	end

	// ****************************************************************
	// access and compare tasks
	// ****************************************************************
	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %0h exp %0h", $time, got, exp);
		end
	endtask

	task automatic acc(input logic we, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		@(negedge mclk);
		host_req = 1'b1;
		host_we = we;
		host_addr = a;
		host_be = be;
		host_wdata = d;
		@(negedge mclk);
		host_req = 1'b0;
		acked = host_ack;
		retried = host_retry;
		if (host_ack && !we) rd = host_rdata;
	endtask

	// repeat reads until accepted, optionally until reload clears
	task automatic rd_ok(input logic w29);
		acked = 1'b0;
		repeat (3000) if (!acked || (w29 && rd[29])) acc(1'b0, 8'h6C, 4'hF, 32'h0);
	endtask

	// pins given as cs, sk, di
	task automatic ee_w(input logic [2:0] p);
		acc(1'b1, 8'h6C, 4'h8, {5'h0, p[0], p[2], p[1], 24'h0});
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ****************************************************************
	// test sequence
	// ****************************************************************
	initial begin
		repeat (3) @(negedge mclk);
		rstn = 1'b1;
		chk(local_cfg, DEF_CFG);
		acc(1'b0, 8'h6C, 4'hF, 32'h0);
		chk({acked, retried}, 2'b01);
		rd_ok(1'b0);
		chk(rd & MASK27, 32'h9002767E);
		chk(local_cfg, LOADED);
		$display("test boot done");
		acc(1'b1, 8'h6C, 4'h3, 32'hFFFFABCD);
		for (int i = 0; i < 5; i++) begin
			{cyc_dma_rd, cyc_dma_wr, cyc_dm_rd, cyc_dm_wr} = (i < 4) ? 4'h8 >> i : 4'h7;
			acc(1'b0, 8'h6C, 4'hF, 32'h0);
			chk(pci_cmd, 4'(16'hABCD >> (4 * ((i < 4) ? i : 1))));
		end
		{cyc_dma_rd, cyc_dma_wr, cyc_dm_rd, cyc_dm_wr} = 4'h8; // dma read stands for the rest of the test, set after the last read is answered
		chk(rd & MASK27, 32'h9002ABCD);
		$display("test command codes done");
		acc(1'b1, 8'h6C, 4'h4, 32'h00010000);
		general_purpose_input_pin = 1'b0;
		acc(1'b0, 8'h6C, 4'hF, 32'h0);
		chk(general_purpose_output_pin, 1'b1);
		chk(rd[17:16], 2'b01);
		acc(1'b1, 8'h70, 4'hF, 32'h0);
		chk({acked, retried}, 2'b10);
		acc(1'b0, 8'h70, 4'hF, 32'h0);
		chk({acked, rd}, {1'b1, 32'h0});
		acc(1'b0, 8'h6C, 4'hF, 32'h0);
		chk(rd[16:0], 17'h1ABCD);
		$display("test user pins and decode done");
		acc(1'b1, 8'h6C, 4'h8, 32'h40000000);
		acc(1'b0, 8'h6C, 4'hF, 32'h0);
		chk({local_reset_output_n, rd[30], rd[16:0]}, {2'b01, 17'h1ABCD});
		chk(local_cfg, LOADED);
		acc(1'b1, 8'h6C, 4'h8, 32'h0);
		@(negedge mclk);
		chk(local_reset_output_n, 1'b1);
		$display("test software reset done");
		ee_w(3'b111);
		@(negedge mclk);
		chk({ee_cs, ee_sk, ee_di}, 3'b111);
		ee_w(3'b000);
		@(negedge mclk);
		chk({ee_cs, ee_sk, ee_di}, 3'b000);
		for (int i = 8; i >= 0; i--) begin
			ee_w({2'b10, HDR[i]});
			ee_w({2'b11, HDR[i]});
		end
		for (int i = 15; i >= 0; i--) begin
			ee_w(3'b100);
			ee_w(3'b110);
			acc(1'b0, 8'h6C, 4'hF, 32'h0);
			w[i] = rd[27];
		end
		chk(w, 16'hA501);
		ee_w(3'b000);
		$display("test bit banged read done");
		ee_blank = 1'b1;
		acc(1'b1, 8'h6C, 4'h8, 32'h20000000);
		rd_ok(1'b0);
		chk(rd[29], 1'b1);
		rd_ok(1'b1);
		chk(rd[29:28], 2'b00);
		chk(local_cfg, LOADED);
		$display("test reload done");
		init_bypass_input_n = 1'b0;
		rstn = 1'b0;
		repeat (2) @(negedge mclk);
		rstn = 1'b1;
		acc(1'b0, 8'h6C, 4'hF, 32'h0);
		chk({acked, rd & MASK27}, {1'b1, 32'h8000767E});
		$display("test bypass done");
		results();
	end
endmodule // tb_top
